//--- hdl/lfrc_defs.svh
// Register offsets, field positions, reset values and counts for the LF receiver control
`ifndef LFRC_DEFS_SVH
`define LFRC_DEFS_SVH

`define LFRC_ADDR_W      8
`define LFRC_ADDR_CTL3   8'h22
`define LFRC_ADDR_MODE   8'h24
`define LFRC_ADDR_STAT   8'h25
`define LFRC_ADDR_MASK   8'h26

`define LFRC_BIT_LEVEL   7
`define LFRC_BIT_ALT     6

`define LFRC_ALT_RST     1'b0
`define LFRC_SYNC_RST    2'h1
`define LFRC_CDT_RST     4'h0
`define LFRC_MODE_RST    1'b1

`define LFRC_EV_W        3
`define LFRC_EV_FOUND    0
`define LFRC_EV_TOGGLE   1
`define LFRC_EV_DATA     2

`define LFRC_CNT_W       11
`define LFRC_CNT_BASE    11'h008
`define LFRC_CNT_BASE_HI 11'h010

`endif

//--- hdl/lfrc_pkg.sv
// Types shared by the LF receiver control logic
package lfrc_pkg;

    // Carrier validation sequencer states
    typedef enum logic [1:0] {
        lfrc_st_idle  = 2'b00,
        lfrc_st_count = 2'b01,
        lfrc_st_done  = 2'b10
    } lfrc_state_e;

    // Signals arriving from the analog detector
    typedef struct packed {
        logic level;
        logic period_tick;
        logic on_start;
    } lfrc_det_s;

endpackage : lfrc_pkg

//--- hdl/lfrc_validate.sv
// Carrier validation counter for one detector on-period
`timescale 1ns/1ps
`default_nettype none
`include "lfrc_defs.svh"

module lfrc_validate (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire lfrc_pkg::lfrc_det_s det,
    input  wire logic              carrier_mode,
    input  wire logic [3:0]        cdt_code,
    output var  logic              valid
);

    lfrc_pkg::lfrc_state_e           st_q;
    lfrc_pkg::lfrc_state_e           st_d;
    logic [`LFRC_CNT_W-1:0]          cnt_q;
    logic [`LFRC_CNT_W-1:0]          cnt_d;
    logic                            valid_q;
    logic                            valid_d;

    // Carrier periods needed, by validation code and mode
    function automatic logic [`LFRC_CNT_W-1:0] need_periods(
        input logic [3:0] code,
        input logic       cmode
    );
        logic [`LFRC_CNT_W-1:0] n;
        if (code[3]) begin
            n = `LFRC_CNT_BASE_HI << code[1:0];
        end else if (cmode) begin
            n = `LFRC_CNT_BASE << code[2:0];
        end else begin
            n = `LFRC_CNT_BASE;
        end
        return n;
    endfunction : need_periods

    // Count carrier periods while the slicer stays high
    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        valid_d = 1'b0;
        case (st_q)
            lfrc_pkg::lfrc_st_idle: begin
                cnt_d = '0;
            end
            lfrc_pkg::lfrc_st_count: begin
                if (!det.level) begin
                    cnt_d = '0;
                end else if (det.period_tick) begin
                    if (cnt_q + 11'h001 >= need_periods(cdt_code, carrier_mode)) begin
                        valid_d = 1'b1;
                        st_d    = lfrc_pkg::lfrc_st_done;
                    end else begin
                        cnt_d = cnt_q + 11'h001;
                    end
                end
            end
            lfrc_pkg::lfrc_st_done: begin
                cnt_d = cnt_q; // Code ignored for rest of the on-period
            end
            default: begin
                st_d = lfrc_pkg::lfrc_st_idle;
            end
        endcase
        // A new on-period restarts counting under the mode now in force
        if (det.on_start) begin
            st_d    = lfrc_pkg::lfrc_st_count;
            cnt_d   = '0;
            valid_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q    <= lfrc_pkg::lfrc_st_idle;
            cnt_q   <= '0;
            valid_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            valid_q <= valid_d;
        end
    end

    assign valid = valid_q;

    chk_start_no_valid: assert property (@(posedge clk) disable iff (srst)
        det.on_start |=> !valid_q)
        else $error("validation reported in the on-period start cycle");

    chk_valid_needs_level: assert property (@(posedge clk) disable iff (srst)
        valid_q |-> $past(det.level) && $past(det.period_tick))
        else $error("validation without a carrier period");

endmodule : lfrc_validate
`default_nettype wire

//--- hdl/lfrc_ctl.sv
// LF receiver control register, mode alternation and carrier-found events
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "lfrc_defs.svh"

// Summary of operation
// - 8-bit control register at 0x22: level, alternation, preamble, validation time.
// - Bit 7 follows the live detector slicer output, unsynchronised to accesses.
// - Level bit is read-only; writes ignored; reset never touches it.
// - Level bit reads 1 above detection threshold, 0 otherwise.
// - Alternation enable is read/write and cleared by reset.
// - Alternation off: carrier mode select keeps software value and decides mode.
// - Alternation on: mode select inverts at each on-sequence after the first, starting from software value.
// - Mode select 1 is carrier mode, 0 data mode; data chain stays on until end.
// - Preamble select resets to 01; code 00 is factory test only.
// - Reset clears validation time field, giving 8 carrier periods.
// - In carrier mode, carrier held for validation time and count reached sets found flag, interrupts.
module lfrc_ctl (
    input  wire logic                     clk,
    input  wire logic                     srst,
    input  wire logic [`LFRC_ADDR_W-1:0]  addr,
    input  wire logic [7:0]               wdata,
    input  wire logic                     wr,
    input  wire logic                     rd,
    output var  logic [7:0]               rdata,
    input  wire lfrc_pkg::lfrc_det_s      det,
    input  wire logic                     count_hit,
    input  wire logic                     msg_end,
    output var  logic                     carrier_mode_select,
    output var  logic [1:0]               preamble_sel,
    output var  logic [3:0]               carrier_validate_time,
    output var  logic                     receive_chain_on,
    output var  logic                     irq
);

    logic                    alt_q;
    logic                    alt_d;
    logic [1:0]              sync_q;
    logic [1:0]              sync_d;
    logic [3:0]              cdt_q;
    logic [3:0]              cdt_d;
    logic                    mode_q;
    logic                    mode_d;
    logic                    first_q;
    logic                    first_d;
    logic                    chain_q;
    logic                    chain_d;
    logic [`LFRC_EV_W-1:0]   stat_q;
    logic [`LFRC_EV_W-1:0]   stat_d;
    logic [`LFRC_EV_W-1:0]   mask_q;
    logic [`LFRC_EV_W-1:0]   mask_d;
    logic [`LFRC_EV_W-1:0]   ev;
    logic [7:0]              rdata_q;
    logic [7:0]              rdata_d;
    logic                    irq_q;
    logic                    irq_d;
    logic                    valid;
    logic                    wr_ctl3;
    logic                    wr_mode;
    logic                    wr_stat;
    logic                    wr_mask;
    logic                    toggle;

    // Write decode
    assign wr_ctl3 = wr && (addr == `LFRC_ADDR_CTL3);
    assign wr_mode = wr && (addr == `LFRC_ADDR_MODE);
    assign wr_stat = wr && (addr == `LFRC_ADDR_STAT);
    assign wr_mask = wr && (addr == `LFRC_ADDR_MASK);

    // Hardware inverts the mode only after the first on-sequence of a run
    assign toggle = alt_q && det.on_start && !first_q;

    // Carrier validation for the current on-period
    lfrc_validate u_validate (
        .clk          (clk),
        .srst         (srst),
        .det          (det),
        .carrier_mode (mode_q),
        .cdt_code     (cdt_q),
        .valid        (valid)
    );

    // Control fields; bit 7 of a write is dropped
    always_comb begin
        alt_d  = alt_q;
        sync_d = sync_q;
        cdt_d  = cdt_q;
        if (wr_ctl3) begin // Bit 7 has no storage
            alt_d  = wdata[`LFRC_BIT_ALT];
            sync_d = wdata[5:4];
            cdt_d  = wdata[3:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            alt_q  <= `LFRC_ALT_RST;
            sync_q <= `LFRC_SYNC_RST;
            cdt_q  <= `LFRC_CDT_RST;
        end else begin
            alt_q  <= alt_d;
            sync_q <= sync_d;
            cdt_q  <= cdt_d;
        end
    end

    // Mode select: software write wins over a same-cycle toggle
    always_comb begin
        mode_d  = mode_q;
        first_d = first_q;
        if (det.on_start && alt_q) begin
            first_d = 1'b0;
        end
        if (toggle) begin
            mode_d = !mode_q;
        end
        if (wr_mode) begin
            mode_d  = wdata[0];
            first_d = 1'b1;
        end
        if (wr_ctl3 && wdata[`LFRC_BIT_ALT] && !alt_q) begin
            first_d = 1'b1; // Run starts from the software mode
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_q  <= `LFRC_MODE_RST;
            first_q <= 1'b1;
        end else begin
            mode_q  <= mode_d;
            first_q <= first_d;
        end
    end

    // Data receive chain held on from data-mode validation until message end
    always_comb begin
        chain_d = chain_q;
        if (msg_end) begin
            chain_d = 1'b0;
        end
        if (valid && !mode_q) begin
            chain_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            chain_q <= 1'b0;
        end else begin
            chain_q <= chain_d;
        end
    end

    // Event sources
    always_comb begin
        ev                 = '0;
        ev[`LFRC_EV_FOUND]  = valid && mode_q && count_hit;
        ev[`LFRC_EV_TOGGLE] = toggle;
        ev[`LFRC_EV_DATA]   = valid && !mode_q;
    end

    // Sticky status, write one to clear, set wins; mask and interrupt
    always_comb begin
        stat_d = stat_q;
        mask_d = mask_q;
        if (wr_stat) begin
            stat_d = stat_q & ~wdata[`LFRC_EV_W-1:0];
        end
        stat_d = stat_d | ev;
        if (wr_mask) begin
            mask_d = wdata[`LFRC_EV_W-1:0];
        end
        irq_d = |(stat_d & mask_d);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            stat_q <= '0;
            mask_q <= '0;
            irq_q  <= 1'b0;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q  <= irq_d;
        end
    end

    // Read data, valid in the cycle after the strobe
    always_comb begin
        rdata_d = 8'h00;
        if (rd) begin
            case (addr)
                `LFRC_ADDR_CTL3: begin
                    rdata_d = {det.level, alt_q, sync_q, cdt_q};
                end
                `LFRC_ADDR_MODE: begin
                    rdata_d = {7'h00, mode_q};
                end
                `LFRC_ADDR_STAT: begin
                    rdata_d = {5'h00, stat_q};
                end
                `LFRC_ADDR_MASK: begin
                    rdata_d = {5'h00, mask_q};
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Outputs straight from registers
    assign rdata                 = rdata_q;
    assign irq                   = irq_q;
    assign carrier_mode_select   = mode_q;
    assign preamble_sel          = sync_q;
    assign carrier_validate_time = cdt_q;
    assign receive_chain_on      = chain_q;

    chk_ctl3_read_map: assert property (@(posedge clk) disable iff (srst)
        rd && addr == `LFRC_ADDR_CTL3 |=>
            rdata_q[6:0] == {$past(alt_q), $past(sync_q), $past(cdt_q)})
        else $error("control register read layout wrong");

    chk_level_live: assert property (@(posedge clk) disable iff (srst)
        rd && addr == `LFRC_ADDR_CTL3 |=> rdata_q[7] == $past(det.level))
        else $error("level bit does not follow the slicer");

    chk_level_high: assert property (@(posedge clk) disable iff (srst)
        rd && addr == `LFRC_ADDR_CTL3 && det.level |=> rdata_q[7])
        else $error("level bit low while above threshold");

    chk_ctl3_write: assert property (@(posedge clk) disable iff (srst)
        wr_ctl3 |=> alt_q == $past(wdata[6]) && sync_q == $past(wdata[5:4])
            && cdt_q == $past(wdata[3:0]))
        else $error("control register write not stored");

    chk_reset_values: assert property (@(posedge clk)
        srst |=> !alt_q && sync_q == 2'h1 && cdt_q == 4'h0)
        else $error("control fields wrong after reset");

    chk_mode_hold: assert property (@(posedge clk) disable iff (srst)
        !alt_q && !wr_mode |=> mode_q == $past(mode_q))
        else $error("mode changed with alternation off");

    chk_mode_flip: assert property (@(posedge clk) disable iff (srst)
        alt_q && det.on_start && !first_q && !wr_mode |=> mode_q != $past(mode_q))
        else $error("mode not inverted on new on-sequence");

    chk_first_keeps: assert property (@(posedge clk) disable iff (srst)
        alt_q && det.on_start && first_q && !wr_mode |=> mode_q == $past(mode_q))
        else $error("first on-sequence did not use software mode");

    chk_data_chain: assert property (@(posedge clk) disable iff (srst)
        valid && !mode_q |=> chain_q ##1 (chain_q || $past(msg_end)))
        else $error("data chain not held on after validation");

    chk_found_flag: assert property (@(posedge clk) disable iff (srst)
        valid && mode_q && count_hit |=> stat_q[`LFRC_EV_FOUND])
        else $error("carrier found flag not set");

    chk_irq_level: assert property (@(posedge clk) disable iff (srst)
        irq_q == |(stat_q & mask_q))
        else $error("interrupt disagrees with status and mask");

endmodule : lfrc_ctl
`default_nettype wire

//--- tb/lfrc_det_model.sv
// Behavioural detector front end: on-sequences with a train of carrier periods
`timescale 1ns/1ps
`default_nettype none

module lfrc_det_model (
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic                 go,
    input  wire logic [10:0]          n_ticks,
    input  wire logic                 slow,
    input  wire logic                 hold_level,
    output var  lfrc_pkg::lfrc_det_s  det,
    output var  logic                 busy
);
    logic        start_q;
    logic        ph_q;
    logic [10:0] left_q;
    logic        tick;

    // Carrier present while periods remain; slow mode ticks every second cycle
    always_comb begin
        tick            = (left_q != 11'h000) && !start_q && (!slow || ph_q);
        det.on_start    = start_q;
        det.period_tick = tick;
        det.level       = hold_level | ((left_q != 11'h000) && !start_q);
        busy            = start_q | (left_q != 11'h000);
    end

    // One on-sequence pulse, then exactly n_ticks carrier periods; reset clears the train, leaving the slicer at hold_level
    always_ff @(posedge clk) begin
        if (srst) begin
            start_q <= 1'b0;
            left_q  <= 11'h000;
            ph_q    <= 1'b0;
        end else begin
            start_q <= go;
            if (go) begin
                left_q <= n_ticks;
                ph_q   <= 1'b0;
            end else if ((left_q != 11'h000) && !start_q) begin
                ph_q <= ~ph_q;
                if (tick) left_q <= left_q - 11'h001;
            end
        end
    end
endmodule : lfrc_det_model
`default_nettype wire

//--- tb/lf_rx_mode_control_reg_test.sv
// Self-checking bench for the LF receiver control register block
`timescale 1ns/1ps
`default_nettype none
`include "lfrc_defs.svh"

module lf_rx_mode_control_reg_test;
    logic                clk;
    logic                srst;
    logic [7:0]          addr;
    logic [7:0]          wdata;
    logic                wr;
    logic                rd;
    logic [7:0]          rdata;
    lfrc_pkg::lfrc_det_s det;
    logic                count_hit;
    logic                msg_end;
    logic                cmode;
    logic [1:0]          psel;
    logic [3:0]          cdt;
    logic                chain_on;
    logic                irq;
    logic                go;
    logic [10:0]         n_ticks;
    logic                slow;
    logic                hold_level;
    logic                busy;
    logic [7:0]          v;
    logic [3:0]          c;
    logic                e;
    int                  n;
    int                  mismatches;
    int                  samples_checked;
    int                  cyc;

    lfrc_ctl dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .det(det), .count_hit(count_hit), .msg_end(msg_end),
        .carrier_mode_select(cmode), .preamble_sel(psel), .carrier_validate_time(cdt),
        .receive_chain_on(chain_on), .irq(irq));
    lfrc_det_model model (.clk(clk), .srst(srst), .go(go), .n_ticks(n_ticks), .slow(slow),
        .hold_level(hold_level), .det(det), .busy(busy));

    // Free-running clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp, what);
    endtask : rd_chk

    // One detector on-period, then the fixed flag and interrupt latency
    task automatic run_period(input int nt, input logic s);
        @(posedge clk);
        go      <= 1'b1;
        n_ticks <= 11'(nt);
        slow    <= s;
        @(posedge clk);
        go <= 1'b0;
        for (int i = 0; i < 3000; i++) begin
            @(posedge clk);
            #1;
            if (!busy) break;
        end
        repeat (4) @(posedge clk);
        #1;
    endtask : run_period

    function automatic logic [7:0] ctl3_exp(input logic lvl, input logic [7:0] w);
        return {lvl, w[6:0]};
    endfunction : ctl3_exp

    function automatic int ticks_for(input logic [3:0] code, input logic cm);
        if (code[3]) return 16 << code[1:0];
        return cm ? (8 << code[2:0]) : 8;
    endfunction : ticks_for

    // Main sequence
    initial begin
        srst = 1'b1; addr = 8'h00; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
        count_hit = 1'b0; msg_end = 1'b0; go = 1'b0; n_ticks = 11'h000;
        slow = 1'b0; hold_level = 1'b0;
        v = 8'($urandom(32'h859aecce));
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rd_chk(`LFRC_ADDR_CTL3, 8'h10, "ctl3 reset");
        check({psel, cdt, 1'b0, cmode}, 8'h41, "field outputs reset");
        rd_chk(`LFRC_ADDR_MODE, 8'h01, "mode reset");
        rd_chk(`LFRC_ADDR_STAT, 8'h00, "status reset");
        rd_chk(`LFRC_ADDR_MASK, 8'h00, "mask reset");
        wr_reg(8'h30, 8'hFF);
        rd_chk(8'h30, 8'h00, "unmapped");
        hold_level <= 1'b1;
        rd_chk(`LFRC_ADDR_CTL3, 8'h90, "level high");
        hold_level <= 1'b0;
        wr_reg(`LFRC_ADDR_CTL3, 8'hFF);
        rd_chk(`LFRC_ADDR_CTL3, 8'h7F, "level write ignored");
        hold_level <= 1'b1;
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        rd_chk(`LFRC_ADDR_CTL3, 8'h90, "level through reset");
        hold_level <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            v = (i == 0) ? 8'hC0 : 8'($urandom);
            wr_reg(`LFRC_ADDR_CTL3, v);
            rd_chk(`LFRC_ADDR_CTL3, ctl3_exp(1'b0, v), "ctl3 readback");
            check({2'h0, psel, cdt}, {2'h0, v[5:0]}, "field outputs");
        end
        // Alternation off, then on
        wr_reg(`LFRC_ADDR_CTL3, 8'h10);
        for (int m = 1; m >= 0; m--) begin
            wr_reg(`LFRC_ADDR_MODE, 8'(m));
            repeat (2) run_period(4, 1'b0);
            check({7'h0, cmode}, 8'(m), "mode held");
        end
        wr_reg(`LFRC_ADDR_CTL3, 8'h50);
        wr_reg(`LFRC_ADDR_MODE, 8'h01);
        wr_reg(`LFRC_ADDR_STAT, 8'hFF);
        e = 1'b1;
        for (int k = 0; k < 4; k++) begin
            run_period(4, 1'b0);
            if (k > 0) e = ~e;
            check({7'h0, cmode}, {7'h0, e}, "mode toggle");
            rd_chk(`LFRC_ADDR_MODE, {7'h0, e}, "active mode read");
        end
        rd_chk(`LFRC_ADDR_STAT, 8'h02, "toggle event");
        // Carrier validation over several time codes
        for (int j = 0; j < 4; j++) begin
            c = (j < 2) ? 4'(j) : 4'(j + 6);
            n = ticks_for(c, 1'b1);
            wr_reg(`LFRC_ADDR_CTL3, {4'h1, c});
            wr_reg(`LFRC_ADDR_MODE, 8'h01);
            wr_reg(`LFRC_ADDR_STAT, 8'hFF);
            wr_reg(`LFRC_ADDR_MASK, 8'h01);
            count_hit <= 1'b1;
            run_period(n - 1, 1'b0);
            rd_chk(`LFRC_ADDR_STAT, 8'h00, "short carrier");
            run_period(n, c[0]);
            rd_chk(`LFRC_ADDR_STAT, 8'h01, "carrier found");
            check({7'h0, irq}, 8'h01, "irq raised");
            wr_reg(`LFRC_ADDR_STAT, 8'h01);
            @(posedge clk);
            #1;
            check({7'h0, irq}, 8'h00, "irq cleared");
            count_hit <= 1'b0;
            run_period(n, 1'b0);
            rd_chk(`LFRC_ADDR_STAT, 8'h00, "count not reached");
            wr_reg(`LFRC_ADDR_MASK, 8'h00);
            count_hit <= 1'b1;
            run_period(n, 1'b0);
            check({7'h0, irq}, 8'h00, "irq masked");
        end
        // Data mode keeps the chain on until the message ends
        count_hit <= 1'b0;
        wr_reg(`LFRC_ADDR_CTL3, 8'h13);
        wr_reg(`LFRC_ADDR_MODE, 8'h00);
        wr_reg(`LFRC_ADDR_STAT, 8'hFF);
        run_period(ticks_for(4'h3, 1'b0), 1'b0);
        check({7'h0, chain_on}, 8'h01, "chain on");
        rd_chk(`LFRC_ADDR_STAT, 8'h04, "chain event");
        msg_end <= 1'b1;
        @(posedge clk);
        msg_end <= 1'b0;
        @(posedge clk);
        #1;
        check({7'h0, chain_on}, 8'h00, "chain off");
        give_verdict();
    end
endmodule : lf_rx_mode_control_reg_test
`default_nettype wire
